/* logic/pin_ctrl_cfg.svh */
// Constants and summary of the interrupt, clock and boot pin control block
// Summary of operation
// - Both user interrupt inputs are detected on an edge whose polarity software selects per input.
// - The second user interrupt pin also serves as the ADC start trigger or as a plain port pin.
// - The clock output pin carries the CPU clock or the watchdog clock as chosen by bit 14 of the system control word.
// - The clock output pin becomes a port pin whenever it is not outputting a clock.
// - A falling edge on the second protection input raises an interrupt and floats all event manager B PWM pins.
// - The crystal output pin floats whenever the emulation-off input is held low.
// - In the boot step after reset is released, the boot-enable pin is sampled into bit 3 of the second system control word, then drives the flag.
// - After reset the flag output is driven high until software changes it.
// - Mask ROM variants have no boot ROM and offer no boot-enable selection from the shared pin.
// - Every port pin is an input right after reset until software sets its direction.
`ifndef PIN_CTRL_CFG_SVH
`define PIN_CTRL_CFG_SVH
`define CLKSEL_BIT       14
`define BOOTEN_BIT       3
`define SYSCTRL_RST      16'h0000
`define SYSCTRL_TWO_RST  16'h0000
`define FLAG_RST         1'b1
`define PWM_B_WIDTH      8
`endif

/* logic/pin_ctrl_pkg.sv */
// Types for the interrupt, clock and boot pin control block
package pin_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_BOOT  = 3'b010,
    ST_RUN   = 3'b100
  } boot_state_t;
endpackage : pin_ctrl_pkg

/* logic/edge_catch.sv */
// Synchroniser, edge detector and pending flag for one input pin
module edge_catch
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic pinIn,
  input  wire logic riseSel,
  input  wire logic ack,
  output logic      pending_ff,
  output logic      edgePulse
);
  logic syncA_ff;
  logic syncB_ff;
  logic last_ff;
  logic nxt_pending;

  assign edgePulse   = riseSel ? (syncB_ff & ~last_ff) : (~syncB_ff & last_ff);
  assign nxt_pending = edgePulse | (pending_ff & ~ack);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncA_ff   <= 1'b1;
      syncB_ff   <= 1'b1;
      last_ff    <= 1'b1;
      pending_ff <= 1'b0;
    end
    else
    begin
      syncA_ff   <= pinIn;
      syncB_ff   <= syncA_ff;
      last_ff    <= syncB_ff;
      pending_ff <= nxt_pending;
    end
  end

  pend_set_a: assert property (@(posedge clk) disable iff (!arst_n) edgePulse |=> pending_ff)
    else $error("pending flag missed an edge");
endmodule : edge_catch

/* logic/intr_clock_boot_pin_ctrl.sv */
// Interrupt, clock output, protection and boot pin control
`include "pin_ctrl_cfg.svh"
module intr_clock_boot_pin_ctrl
#(
  parameter bit HAS_BOOT_ROM = 1'b1,
  parameter int PWM_W        = `PWM_B_WIDTH
)
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             watchdog_clock,
  input  wire logic             user_irq_in_a,
  input  wire logic             user_irq_in_b,
  input  wire logic             power_protect_in_b,
  input  wire logic             emulation_off_n,
  input  wire logic             bootPinIn,
  input  wire logic             irqARiseSel,
  input  wire logic             irqBRiseSel,
  input  wire logic             irqAAck,
  input  wire logic             irqBAck,
  input  wire logic             protectAck,
  input  wire logic             irqBAsAdcStart,
  input  wire logic             clkOutEnable,
  input  wire logic [15:0]      system_ctrl_status_reg,
  input  wire logic             flagWrite,
  input  wire logic             flagValue,
  input  wire logic             gpioDirWrite,
  input  wire logic [2:0]       gpioDirValue,
  input  wire logic [2:0]       gpioOutValue,
  input  wire logic [PWM_W-1:0] pwmDriveIn,
  output logic                  irqAPending,
  output logic                  irqBPending,
  output logic                  protectIrq,
  output logic                  adc_ext_start_in,
  output logic [PWM_W-1:0]      pwmOutEn,
  output logic                  cpu_clock_out,
  output logic                  cpuClockOutEn,
  output logic                  crystalOutEn,
  output logic [15:0]           system_ctrl_status_reg_two,
  output logic                  external_flag_out,
  output logic                  bootPinOutEn,
  output logic [2:0]            gpioOutEn,
  output logic [2:0]            gpioOut
);
  // ******************************
  // Edge catchers
  // ******************************
  logic aPend;
  logic bPend;
  logic pPend;
  logic bEdge;
  logic pEdge;
  logic cpuDiv_ff;
  logic wdSync1_ff;
  logic wdSync2_ff;
  logic protectLatch_ff;
  logic adcStart_ff;
  logic [2:0] gpioDir_ff;
  logic [2:0] gpioOut_ff;
  logic flag_ff;
  logic [15:0] sysCtrlTwo_ff;
  logic clkOutSel_ff;
  logic clkOutEn_ff;
  logic xtalEn_ff;
  logic [PWM_W-1:0] pwmEn_ff;
  pin_ctrl_pkg::boot_state_t state_ff;
  pin_ctrl_pkg::boot_state_t nxt_state;

  edge_catch u_irq_a (.clk(clk), .arst_n(arst_n), .pinIn(user_irq_in_a), .riseSel(irqARiseSel),
                      .ack(irqAAck), .pending_ff(aPend), .edgePulse());
  edge_catch u_irq_b (.clk(clk), .arst_n(arst_n), .pinIn(user_irq_in_b), .riseSel(irqBRiseSel),
                      .ack(irqBAck), .pending_ff(bPend), .edgePulse(bEdge));
  edge_catch u_prot  (.clk(clk), .arst_n(arst_n), .pinIn(power_protect_in_b), .riseSel(1'b0),
                      .ack(protectAck), .pending_ff(pPend), .edgePulse(pEdge));

  assign irqAPending = aPend;
  assign irqBPending = bPend;
  assign protectIrq  = pPend;

  // ******************************
  // Boot sequence
  // ******************************
  wire takeBoot = (state_ff == pin_ctrl_pkg::ST_BOOT);
  wire bootBit  = HAS_BOOT_ROM ? bootPinIn : 1'b0;

  always_comb
  begin
    unique case (state_ff)
      pin_ctrl_pkg::ST_RESET: nxt_state = pin_ctrl_pkg::ST_BOOT;
      pin_ctrl_pkg::ST_BOOT:  nxt_state = pin_ctrl_pkg::ST_RUN;
      pin_ctrl_pkg::ST_RUN:   nxt_state = pin_ctrl_pkg::ST_RUN;
      default:                nxt_state = pin_ctrl_pkg::ST_RESET;
    endcase
  end

  // ******************************
  // Pin selection
  // ******************************
  wire nxtClkOut  = clkOutSel_ff ? wdSync2_ff : cpuDiv_ff;
  wire clkSelBit  = system_ctrl_status_reg[`CLKSEL_BIT];
  wire [2:0] dirMask = {~clkOutEnable, ~irqBAsAdcStart, 1'b1};
  wire [PWM_W-1:0] nxtPwmEn = (pEdge | protectLatch_ff) ? '0 : pwmDriveIn;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff        <= pin_ctrl_pkg::ST_RESET;
      sysCtrlTwo_ff   <= `SYSCTRL_TWO_RST;
      flag_ff         <= `FLAG_RST;
      gpioDir_ff      <= 3'h0;
      gpioOut_ff      <= 3'h0;
      cpuDiv_ff       <= 1'b0;
      wdSync1_ff      <= 1'b0;
      wdSync2_ff      <= 1'b0;
      clkOutSel_ff    <= 1'b0;
      clkOutEn_ff     <= 1'b0;
      xtalEn_ff       <= 1'b0;
      protectLatch_ff <= 1'b0;
      pwmEn_ff        <= '0;
      adcStart_ff     <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (takeBoot)
        sysCtrlTwo_ff[`BOOTEN_BIT] <= bootBit;
      if (flagWrite)
        flag_ff <= flagValue;
      if (gpioDirWrite)
        gpioDir_ff <= gpioDirValue;
      gpioOut_ff      <= gpioOutValue;
      cpuDiv_ff       <= ~cpuDiv_ff;
      wdSync1_ff      <= watchdog_clock;
      wdSync2_ff      <= wdSync1_ff;
      clkOutSel_ff    <= clkSelBit;
      clkOutEn_ff     <= clkOutEnable;
      xtalEn_ff       <= emulation_off_n;
      protectLatch_ff <= pEdge | (protectLatch_ff & ~protectAck);
      pwmEn_ff        <= nxtPwmEn;
      adcStart_ff     <= irqBAsAdcStart & bEdge;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cpu_clock_out <= 1'b0;
      cpuClockOutEn <= 1'b0;
      gpioOutEn     <= 3'h0;
      gpioOut       <= 3'h0;
      bootPinOutEn  <= 1'b0;
    end
    else
    begin
      cpu_clock_out <= clkOutEn_ff ? nxtClkOut : gpioOut_ff[2];
      cpuClockOutEn <= clkOutEn_ff | gpioDir_ff[2];
      gpioOutEn     <= gpioDir_ff & dirMask;
      gpioOut       <= gpioOut_ff;
      bootPinOutEn  <= (state_ff == pin_ctrl_pkg::ST_RUN);
    end
  end

  assign crystalOutEn               = xtalEn_ff;
  assign pwmOutEn                   = pwmEn_ff;
  assign adc_ext_start_in           = adcStart_ff;
  assign system_ctrl_status_reg_two = sysCtrlTwo_ff;
  assign external_flag_out          = flag_ff;

  // ******************************
  // Checks
  // ******************************
  sequence protEdge_s;
    pEdge;
  endsequence

  pwm_float_a: assert property (@(posedge clk) disable iff (!arst_n) protEdge_s |=> pwmOutEn == '0)
    else $error("pwm outputs not floated after protection edge");
  xtal_float_a: assert property (@(posedge clk) disable iff (!arst_n) !emulation_off_n |=> !crystalOutEn)
    else $error("crystal output driven while emulation off");
  flag_high_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(bootPinOutEn) && !$past(flagWrite, 2) && !$past(flagWrite) |-> external_flag_out)
    else $error("flag not high after reset");
  boot_sample_a: assert property (@(posedge clk) disable iff (!arst_n)
    takeBoot |=> system_ctrl_status_reg_two[`BOOTEN_BIT] == $past(bootBit))
    else $error("boot bit not sampled");
  gpio_input_a: assert property (@(posedge clk) disable iff (!arst_n)
    state_ff == pin_ctrl_pkg::ST_RESET |-> gpioOutEn == 3'h0)
    else $error("port pin driven right after reset");
  adc_start_a: assert property (@(posedge clk) disable iff (!arst_n)
    bEdge && irqBAsAdcStart |=> adc_ext_start_in)
    else $error("adc start missed");
  clk_sel_a: assert property (@(posedge clk) disable iff (!arst_n)
    clkOutEn_ff && !clkOutSel_ff |=> cpu_clock_out == $past(cpuDiv_ff))
    else $error("wrong clock on output pin");
  clk_gpio_a: assert property (@(posedge clk) disable iff (!arst_n)
    !clkOutEn_ff && !gpioDir_ff[2] |=> !cpuClockOutEn)
    else $error("clock pin driven when idle");

  // ******************************
  // Boot, flag and pin checks
  // ******************************
  sequence bootDone_s;
    state_ff == pin_ctrl_pkg::ST_BOOT ##1 state_ff == pin_ctrl_pkg::ST_RUN;
  endsequence

  boot_drive_a: assert property (@(posedge clk) disable iff (!arst_n) bootDone_s |=> bootPinOutEn)
    else $error("boot pin not switched to flag output");
  prot_irq_a: assert property (@(posedge clk) disable iff (!arst_n) protEdge_s |=> protectIrq)
    else $error("protection interrupt not raised");
  pwm_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    protectLatch_ff && !protectAck |=> pwmOutEn == '0)
    else $error("pwm outputs released while protection latched");
  flag_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    flagWrite |=> external_flag_out == $past(flagValue))
    else $error("flag write not applied");
  xtal_drive_a: assert property (@(posedge clk) disable iff (!arst_n) emulation_off_n |=> crystalOutEn)
    else $error("crystal output floated while emulation on");
  adc_port_in_a: assert property (@(posedge clk) disable iff (!arst_n)
    irqBAsAdcStart |=> !gpioOutEn[1])
    else $error("adc start pin driven as output");
endmodule : intr_clock_boot_pin_ctrl

/* bench/intr_clock_boot_pin_ctrl_tb_top.sv */
// Self-checking bench for the interrupt, clock and boot pin control block
`include "pin_ctrl_cfg.svh"
module intr_clock_boot_pin_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // Signals
  // ********
  logic                     clk, arst_n, watchdog_clock, user_irq_in_a, user_irq_in_b, power_protect_in_b;
  logic                     emulation_off_n, bootPinIn, irqARiseSel, irqBRiseSel, irqAAck, irqBAck;
  logic                     protectAck, irqBAsAdcStart, clkOutEnable, flagWrite, flagValue, gpioDirWrite;
  logic [15:0]              system_ctrl_status_reg, system_ctrl_status_reg_two, romCtrlTwo;
  logic [2:0]               gpioDirValue, gpioOutValue, gpioOutEn, gpioOut;
  logic [`PWM_B_WIDTH-1:0]  pwmDriveIn, pwmOutEn;
  logic                     irqAPending, irqBPending, protectIrq, adc_ext_start_in, cpu_clock_out;
  logic                     cpuClockOutEn, crystalOutEn, external_flag_out, bootPinOutEn, prev;
  int                       fail_count = 0;
  int                       samples_checked = 0;
  int                       seen;
  intr_clock_boot_pin_ctrl i_intr_clock_boot_pin_ctrl
  (
    .clk(clk), .arst_n(arst_n), .watchdog_clock(watchdog_clock), .user_irq_in_a(user_irq_in_a),
    .user_irq_in_b(user_irq_in_b), .power_protect_in_b(power_protect_in_b), .emulation_off_n(emulation_off_n),
    .bootPinIn(bootPinIn), .irqARiseSel(irqARiseSel), .irqBRiseSel(irqBRiseSel), .irqAAck(irqAAck),
    .irqBAck(irqBAck), .protectAck(protectAck), .irqBAsAdcStart(irqBAsAdcStart), .clkOutEnable(clkOutEnable),
    .system_ctrl_status_reg(system_ctrl_status_reg), .flagWrite(flagWrite), .flagValue(flagValue),
    .gpioDirWrite(gpioDirWrite), .gpioDirValue(gpioDirValue), .gpioOutValue(gpioOutValue),
    .pwmDriveIn(pwmDriveIn), .irqAPending(irqAPending), .irqBPending(irqBPending), .protectIrq(protectIrq),
    .adc_ext_start_in(adc_ext_start_in), .pwmOutEn(pwmOutEn), .cpu_clock_out(cpu_clock_out),
    .cpuClockOutEn(cpuClockOutEn), .crystalOutEn(crystalOutEn),
    .system_ctrl_status_reg_two(system_ctrl_status_reg_two), .external_flag_out(external_flag_out),
    .bootPinOutEn(bootPinOutEn), .gpioOutEn(gpioOutEn), .gpioOut(gpioOut)
  );
  // Mask ROM variant: boot bit must stay clear
  intr_clock_boot_pin_ctrl #(.HAS_BOOT_ROM(1'b0)) i_intr_clock_boot_pin_ctrl_rom
  (
    .clk(clk), .arst_n(arst_n), .watchdog_clock(watchdog_clock), .user_irq_in_a(user_irq_in_a),
    .user_irq_in_b(user_irq_in_b), .power_protect_in_b(power_protect_in_b), .emulation_off_n(emulation_off_n),
    .bootPinIn(bootPinIn), .irqARiseSel(irqARiseSel), .irqBRiseSel(irqBRiseSel), .irqAAck(irqAAck),
    .irqBAck(irqBAck), .protectAck(protectAck), .irqBAsAdcStart(irqBAsAdcStart), .clkOutEnable(clkOutEnable),
    .system_ctrl_status_reg(system_ctrl_status_reg), .flagWrite(flagWrite), .flagValue(flagValue),
    .gpioDirWrite(gpioDirWrite), .gpioDirValue(gpioDirValue), .gpioOutValue(gpioOutValue),
    .pwmDriveIn(pwmDriveIn), .irqAPending(), .irqBPending(), .protectIrq(), .adc_ext_start_in(), .pwmOutEn(),
    .cpu_clock_out(), .cpuClockOutEn(), .crystalOutEn(), .system_ctrl_status_reg_two(romCtrlTwo),
    .external_flag_out(), .bootPinOutEn(), .gpioOutEn(), .gpioOut()
  );
  always #25 clk = ~clk;
  // ********
  // Helpers
  // ********
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : step
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // ********
  // Scenarios
  // ********
  task automatic t_boot;
    chk("flag in reset", 1, external_flag_out);
    chk("dir in reset", 0, gpioOutEn);
    chk("boot drive in reset", 0, bootPinOutEn);
    arst_n = 1'b1;
    step(4);
    bootPinIn = 1'b0;
    chk("boot drive", 1, bootPinOutEn);
    chk("flag", 1, external_flag_out);
    chk("dir", 0, gpioOutEn);
    step(3);
    chk("boot bit", 1, system_ctrl_status_reg_two[`BOOTEN_BIT]);
    chk("rom boot bit", 0, romCtrlTwo[`BOOTEN_BIT]);
    $display("boot test done");
  endtask : t_boot
  task automatic t_irq;
    user_irq_in_a = 1'b0;
    step(5);
    chk("pend a", 1, irqAPending);
    chk("pend b", 0, irqBPending);
    user_irq_in_a = 1'b1;
    step(5);
    chk("pend a held", 1, irqAPending);
    irqAAck = 1'b1;
    step(1);
    irqAAck = 1'b0;
    step(5);
    chk("pend a rise", 0, irqAPending);
    user_irq_in_b = 1'b1;
    step(5);
    chk("pend b rise", 1, irqBPending);
    $display("irq test done");
  endtask : t_irq
  task automatic t_adc;
    irqBAsAdcStart = 1'b1;
    gpioDirValue = 3'h7;
    gpioDirWrite = 1'b1;
    irqBAck = 1'b1;
    user_irq_in_b = 1'b0;
    step(1);
    gpioDirWrite = 1'b0;
    irqBAck = 1'b0;
    step(5);
    chk("dir adc", 3'h5, gpioOutEn);
    user_irq_in_b = 1'b1;
    seen = 0;
    for (int i = 0; i < 8; i++)
    begin
      step(1);
      if (adc_ext_start_in === 1'b1) seen++;
    end
    chk("adc pulses", 1, seen);
    irqBAsAdcStart = 1'b0;
    step(2);
    chk("dir port", 3'h7, gpioOutEn);
    $display("adc test done");
  endtask : t_adc
  task automatic t_clock;
    clkOutEnable = 1'b1;
    gpioOutValue = 3'h5;
    step(3);
    chk("clk en", 1, cpuClockOutEn);
    chk("e0 dir", 0, gpioOutEn[2]);
    prev = cpu_clock_out;
    step(1);
    chk("cpu clk", !prev, cpu_clock_out);
    system_ctrl_status_reg[`CLKSEL_BIT] = 1'b1;
    watchdog_clock = 1'b1;
    step(5);
    chk("wd clk hi", 1, cpu_clock_out);
    watchdog_clock = 1'b0;
    step(5);
    chk("wd clk lo", 0, cpu_clock_out);
    clkOutEnable = 1'b0;
    step(2);
    chk("clk pin port drive", 1, cpuClockOutEn);
    chk("clk pin port data", 1, cpu_clock_out);
    chk("e0 port", 1, gpioOutEn[2]);
    chk("port data", 3'h5, gpioOut);
    $display("clock test done");
  endtask : t_clock
  task automatic t_protect;
    pwmDriveIn = '1;
    step(2);
    chk("pwm on", 16'h00ff, pwmOutEn);
    power_protect_in_b = 1'b0;
    step(5);
    chk("prot irq", 1, protectIrq);
    chk("pwm float", 0, pwmOutEn);
    power_protect_in_b = 1'b1;
    step(4);
    chk("pwm held", 0, pwmOutEn);
    protectAck = 1'b1;
    step(1);
    protectAck = 1'b0;
    step(2);
    chk("prot clr", 0, protectIrq);
    chk("pwm back", 16'h00ff, pwmOutEn);
    $display("protect test done");
  endtask : t_protect
  task automatic t_xtal_flag;
    chk("xtal on", 1, crystalOutEn);
    emulation_off_n = 1'b0;
    flagWrite = 1'b1;
    step(1);
    flagWrite = 1'b0;
    step(2);
    chk("xtal float", 0, crystalOutEn);
    chk("flag sw", 0, external_flag_out);
    $display("crystal and flag test done");
  endtask : t_xtal_flag
  // ********
  // Main
  // ********
  initial
  begin
    {clk, arst_n, watchdog_clock, user_irq_in_b, irqARiseSel, irqAAck, irqBAck, protectAck} = '0;
    {user_irq_in_a, power_protect_in_b, emulation_off_n, bootPinIn, irqBRiseSel} = '1;
    {irqBAsAdcStart, clkOutEnable, flagWrite, flagValue, gpioDirWrite} = '0;
    {system_ctrl_status_reg, gpioDirValue, gpioOutValue, pwmDriveIn} = '0;
    step(12);
    t_boot();
    t_irq();
    t_adc();
    t_clock();
    t_protect();
    t_xtal_flag();
    close_out();
  end
endmodule : intr_clock_boot_pin_ctrl_tb_top
